// ===== fspc_pkg.sv
// Shared constants and types of the flash self-programming control block.
// Assumes one 20 MHz clock and byte-wide register and flash ports.
package fspc_pkg;

  // Clock and cycle timing
  localparam int CLK_NS = 50;
  localparam int T_PROG_NS = 100000;
  localparam int T_ERASE_NS = 4000000;
  localparam int PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 17;

  // Register map
  localparam logic [7:0] REG_FCTL = 8'h00;
  localparam logic [7:0] REG_ECTL = 8'h01;
  localparam logic [7:0] REG_SEL = 8'h02;
  localparam logic [7:0] REG_ACC = 8'h03;
  localparam logic [7:0] REG_DP0H = 8'h04;
  localparam logic [7:0] REG_DP0L = 8'h05;
  localparam logic [7:0] REG_DP1H = 8'h06;
  localparam logic [7:0] REG_DP1L = 8'h07;
  localparam logic [7:0] REG_PBUF = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h09;

  // Field positions
  localparam int FC_KEY_LO = 4;
  localparam int FC_FPS = 3;
  localparam int FC_MODE_LO = 1;
  localparam int FC_BUSY = 0;
  localparam int EE_AUTOER = 6;
  localparam int EE_ERR = 1;
  localparam int ST_BADARG = 0;
  localparam int ST_PROGBLK = 1;
  localparam int ST_READBLK = 2;
  localparam int ST_EXTBLK = 3;
  localparam int ST_STALL = 4;

  // Launch keys and memory modes
  localparam logic [3:0] KEY_ARM = 4'h5;
  localparam logic [3:0] KEY_GO = 4'ha;
  localparam logic [1:0] MODE_NONE = 2'h3;

  // Routine selectors and arguments
  localparam logic [15:0] ENTRY_ADDR = 16'hfff0;
  localparam logic [7:0] SEL_ERASE = 8'h01;
  localparam logic [7:0] SEL_PBYTE = 8'h02;
  localparam logic [7:0] SEL_BOOT = 8'h06;
  localparam logic [7:0] SEL_PPAGE = 8'h09;
  localparam logic [7:0] SEL_FUSE = 8'h0a;
  localparam logic [15:0] PTR_BSTAT = 16'h0000;
  localparam logic [15:0] PTR_BVEC = 16'h0001;
  localparam logic [15:0] PTR_CLKX2 = 16'h0008;
  localparam logic [15:0] PTR_BLJ = 16'h0004;
  localparam logic [7:0] FUSE_ON = 8'h00;
  localparam logic [7:0] FUSE_OFF = 8'h01;
  localparam logic [7:0] FUSE_OFF_BYTE = 8'hff;
  localparam logic [7:0] BLK0 = 8'h00;
  localparam logic [7:0] BLK1 = 8'h20;
  localparam logic [7:0] BLK2 = 8'h40;
  localparam logic [7:0] BLK3 = 8'h80;
  localparam logic [7:0] BLK4 = 8'hc0;
  localparam logic [7:0] PAGES_8K = 8'h40;
  localparam logic [7:0] PAGES_16K = 8'h80;
  localparam logic [7:0] MAX_PAGE_CNT = 8'h80;
  localparam logic [7:0] HALF_PAGE = 8'h40;
  localparam logic [15:0] PAGE_STEP = 16'h0080;

  // Lock bytes
  localparam logic [7:0] LOCK_PROGRAMMED = 8'h00;

  // Flash spaces and byte sources
  localparam logic [1:0] SP_USER = 2'h0;
  localparam logic [1:0] SP_USIG = 2'h1;
  localparam logic [1:0] SP_FUSE = 2'h2;
  localparam logic [1:0] SRC_ACC = 2'h0;
  localparam logic [1:0] SRC_XRAM = 2'h1;
  localparam logic [1:0] SRC_PBUF = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ERASE = 7'h02,
    ST_EWAIT = 7'h04,
    ST_FETCH = 7'h08,
    ST_RDW = 7'h10,
    ST_PROG = 7'h20,
    ST_PWAIT = 7'h40
  } fspc_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic [1:0] space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fspc_fl_cmd_t;

  typedef struct packed {
    logic prog_block;
    logic read_block;
    logic ext_hi_block;
    logic ext_fetch_deny;
  } fspc_lock_t;

endpackage

// ===== fspc_pbuf.sv
// Temporary page buffer: one write port, registered read data.
// Assumes writer and reader share the system clock.
`timescale 1ns/1ns
module fspc_pbuf #(
  parameter int W = 8,
  parameter int D = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  initial begin
    if (D > (1 << AW) || D < 1) $error("fspc_pbuf: bad depth");
  end

  logic [W-1:0] mem [D];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// ===== fspc_timer.sv
// Down-counter that times one erase or program cycle.
// Assumes a start pulse with a count of at least one.
`timescale 1ns/1ns
module fspc_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_start,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } fspc_tmr_t;

  fspc_tmr_t s;
  fspc_tmr_t n;

  assign o_done = s.done;

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (i_start) begin
      n.cnt = i_count;
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'b1;
      if (s.cnt == W'(1)) begin
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// ===== fspc_core.sv
// Flash self-programming control: lock gating, routine entry, sequencer.
// Assumes a flash array port answering reads one cycle after the strobe,
// an external RAM port with the same timing, and CPU status signals.
// Behaviour
// - All locks erased: none; first: no programming
// - Two locks programmed: block programming and verify
// - Three locks plus boot select: no high execution
// - Routine chosen by registers, entered at FFF0h
// - Selector 01h erases one of five blocks
// - Selector 02h programs accumulator at first pointer
// - Selector 09h copies up to 128 XRAM bytes
// - Selector 06h writes boot status or vector
// - Selector 0Ah programs clock or jump fuse
// - Internal launch stalls CPU through programming
// - CPU resumes after the launching instruction
// - Peripherals run; interrupts held during stall
// - External launch keeps the CPU running
// - Writes only clear bits
// - Erase sets the whole page to FFh
// - Launch needs key 5 then A directly
// - Busy flag while programming; brown-out while busy sets error
// - Page buffer holds 64 bytes, half page
// - Auto-erase clears page before the write
`timescale 1ns/1ns
module fspc_core
  import fspc_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PBUF_DEPTH = 64
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // CPU status and control
  input wire logic i_cpu_fetch,
  input wire logic [15:0] i_cpu_pc,
  input wire logic i_boot_rom_map_enable,
  input wire logic i_exec_internal,
  output logic o_cpu_stall,
  output logic o_irq_hold,
  // Lock bytes, boot select pin and protection flags
  input wire logic [2:0][7:0] i_lock_byte,
  input wire logic i_boot_memory_select,
  output fspc_lock_t o_lock,
  // Flash array port
  output fspc_fl_cmd_t o_fl,
  input wire logic [7:0] i_fl_rdata,
  // External RAM read port
  output logic o_xram_rd,
  output logic [15:0] o_xram_addr,
  input wire logic [7:0] i_xram_rdata,
  // Brown-out detector pin
  input wire logic i_brown_out
);
  initial begin
    if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << TMR_W)) begin
      $error("fspc_core: ERASE_CYCLES out of range");
    end
    if (PBUF_DEPTH != 64) $error("fspc_core: page buffer must be 64");
  end

  typedef struct packed {
    fspc_state_t st;
    logic busy;
    logic stall;
    logic fps;
    logic [1:0] mode;
    logic armed;
    logic auto_erase;
    logic err;
    logic bad_arg;
    logic [7:0] sel;
    logic [7:0] acc;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [63:0] loaded;
    logic [9:0] last_half;
    logic [1:0] src;
    logic [15:0] addr;
    logic [15:0] saddr;
    logic [15:0] eaddr;
    logic [7:0] cnt;
    logic [7:0] ecnt;
    logic do_prog;
    logic [7:0] data;
    logic [7:0] rdata;
    fspc_fl_cmd_t fl;
    logic xram_rd;
    logic [15:0] xram_addr;
    fspc_lock_t lock;
    logic bsel_s1;
    logic bsel_s2;
    logic bo_s1;
    logic bo_s2;
    logic tmr_start;
    logic [TMR_W-1:0] tmr_count;
  } fspc_core_t;

  fspc_core_t s;
  fspc_core_t n;
  logic tmr_done;
  logic [7:0] pb_rdata;
  logic pb_we;
  logic entry;
  logic launch_ll;
  logic adv;
  logic [7:0] newdata;
  logic [7:0] eblk_pages;

  assign o_rdata = s.rdata;
  assign o_cpu_stall = s.stall;
  assign o_irq_hold = s.stall;
  assign o_lock = s.lock;
  assign o_fl = s.fl;
  assign o_xram_rd = s.xram_rd;
  assign o_xram_addr = s.xram_addr;

  fspc_pbuf #(.W(8), .D(PBUF_DEPTH), .AW(6)) u_pbuf (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_we(pb_we),
    .i_waddr(s.dp0[5:0]),
    .i_wdata(i_wdata),
    .i_raddr(s.addr[5:0]),
    .o_rdata(pb_rdata)
  );

  fspc_timer #(.W(TMR_W)) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_start(s.tmr_start),
    .i_count(s.tmr_count),
    .o_done(tmr_done)
  );

  always_comb begin
    n = s;
    pb_we = 1'b0;
    launch_ll = 1'b0;
    adv = 1'b0;
    eblk_pages = 8'h00;
    n.fl.rd = 1'b0;
    n.fl.wr = 1'b0;
    n.fl.erase = 1'b0;
    n.xram_rd = 1'b0;
    n.tmr_start = 1'b0;
    n.rdata = 8'h00;
    n.bsel_s1 = i_boot_memory_select;
    n.bsel_s2 = s.bsel_s1;
    n.bo_s1 = i_brown_out;
    n.bo_s2 = s.bo_s1;

    // Protection levels
    n.lock.prog_block = (i_lock_byte[0] == LOCK_PROGRAMMED);
    n.lock.read_block = (i_lock_byte[0] == LOCK_PROGRAMMED) &&
      (i_lock_byte[1] == LOCK_PROGRAMMED);
    n.lock.ext_hi_block = (i_lock_byte[0] == LOCK_PROGRAMMED) &&
      (i_lock_byte[1] == LOCK_PROGRAMMED) &&
      (i_lock_byte[2] == LOCK_PROGRAMMED) && s.bsel_s2;
    n.lock.ext_fetch_deny = n.lock.ext_hi_block && i_cpu_fetch &&
      !i_exec_internal && i_cpu_pc[15];

    // Register writes
    if (i_wr || i_rd) begin
      n.armed = 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        REG_FCTL: begin
          n.fps = i_wdata[FC_FPS];
          n.mode = i_wdata[FC_MODE_LO +: 2];
          if (i_wdata[FC_KEY_LO +: 4] == KEY_ARM) begin
            n.armed = 1'b1;
          end else if (i_wdata[FC_KEY_LO +: 4] == KEY_GO && s.armed &&
              !s.busy && i_wdata[FC_MODE_LO +: 2] != MODE_NONE) begin
            launch_ll = 1'b1;
          end
        end
        REG_ECTL: begin
          n.auto_erase = i_wdata[EE_AUTOER];
          if (i_wdata[EE_ERR]) n.err = 1'b0;
        end
        REG_SEL: n.sel = i_wdata;
        REG_ACC: n.acc = i_wdata;
        REG_DP0H: n.dp0[15:8] = i_wdata;
        REG_DP0L: n.dp0[7:0] = i_wdata;
        REG_DP1H: n.dp1[15:8] = i_wdata;
        REG_DP1L: n.dp1[7:0] = i_wdata;
        REG_PBUF: begin
          if (s.fps && !s.busy && !s.loaded[s.dp0[5:0]]) begin
            pb_we = 1'b1;
            n.loaded[s.dp0[5:0]] = 1'b1;
            n.last_half = s.dp0[15:6];
          end
        end
        REG_STAT: begin
          if (i_wdata[ST_BADARG]) n.bad_arg = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle
    if (i_rd) begin
      case (i_addr)
        REG_FCTL: n.rdata = {4'h0, s.fps, s.mode, s.busy};
        REG_ECTL: n.rdata = {1'b0, s.auto_erase, 4'h0, s.err, 1'b0};
        REG_SEL: n.rdata = s.sel;
        REG_ACC: n.rdata = s.acc;
        REG_DP0H: n.rdata = s.dp0[15:8];
        REG_DP0L: n.rdata = s.dp0[7:0];
        REG_DP1H: n.rdata = s.dp1[15:8];
        REG_DP1L: n.rdata = s.dp1[7:0];
        REG_STAT: n.rdata = {3'h0, s.stall, s.lock.ext_hi_block,
          s.lock.read_block, s.lock.prog_block, s.bad_arg};
        default: n.rdata = 8'h00;
      endcase
    end

    // Low-level launch from the page buffer
    if (launch_ll) begin
      n.busy = 1'b1;
      n.stall = i_exec_internal;
      n.src = SRC_PBUF;
      n.fl.space = s.mode;
      n.addr = {s.last_half, 6'h00};
      n.cnt = HALF_PAGE;
      n.eaddr = {s.last_half[9:1], 7'h00};
      n.ecnt = 8'h01;
      n.do_prog = 1'b1;
      n.st = s.auto_erase ? ST_ERASE : ST_FETCH;
    end

    // Routine entry at the shared address, run without stalling the CPU
    entry = i_cpu_fetch && (i_cpu_pc == ENTRY_ADDR) &&
      i_boot_rom_map_enable && !s.busy && !launch_ll;
    if (entry) begin
      n.src = SRC_ACC;
      n.data = s.acc;
      n.addr = s.dp0;
      n.saddr = s.dp1;
      n.cnt = 8'h01;
      n.do_prog = 1'b0;
      n.fl.space = SP_USER;
      case (s.sel)
        SEL_ERASE: begin
          case (s.dp0[15:8])
            BLK0, BLK1: eblk_pages = PAGES_8K;
            BLK2, BLK3, BLK4: eblk_pages = PAGES_16K;
            default: eblk_pages = 8'h00;
          endcase
          if (eblk_pages != 8'h00) begin
            n.eaddr = {s.dp0[15:8], 8'h00};
            n.ecnt = eblk_pages;
            n.busy = 1'b1;
            n.st = ST_ERASE;
          end else begin
            n.bad_arg = 1'b1;
          end
        end
        SEL_PBYTE: begin
          n.busy = 1'b1;
          n.st = ST_FETCH;
        end
        SEL_PPAGE: begin
          if (s.acc != 8'h00 && s.acc <= MAX_PAGE_CNT) begin
            n.src = SRC_XRAM;
            n.cnt = s.acc;
            n.busy = 1'b1;
            n.st = ST_FETCH;
          end else begin
            n.bad_arg = 1'b1;
          end
        end
        SEL_BOOT: begin
          if (s.dp0 == PTR_BSTAT || s.dp0 == PTR_BVEC) begin
            n.fl.space = SP_USIG;
            n.busy = 1'b1;
            n.st = ST_FETCH;
          end else begin
            n.bad_arg = 1'b1;
          end
        end
        SEL_FUSE: begin
          if ((s.dp0 == PTR_CLKX2 || s.dp0 == PTR_BLJ) &&
              (s.acc == FUSE_ON || s.acc == FUSE_OFF)) begin
            n.fl.space = SP_FUSE;
            n.data = (s.acc == FUSE_ON) ? FUSE_ON : FUSE_OFF_BYTE;
            n.busy = 1'b1;
            n.st = ST_FETCH;
          end else begin
            n.bad_arg = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Sequencer
    newdata = (s.src == SRC_PBUF) ? pb_rdata :
      (s.src == SRC_XRAM) ? i_xram_rdata : s.data;
    case (s.st)
      ST_IDLE: begin
      end
      ST_ERASE: begin
        n.fl.erase = 1'b1;
        n.fl.addr = s.eaddr;
        n.tmr_start = 1'b1;
        n.tmr_count = TMR_W'(ERASE_CYCLES);
        n.st = ST_EWAIT;
      end
      ST_EWAIT: begin
        if (tmr_done) begin
          if (s.ecnt == 8'h01) begin
            n.st = s.do_prog ? ST_FETCH : ST_IDLE;
            n.busy = s.do_prog;
            n.stall = s.do_prog && s.stall;
          end else begin
            n.ecnt = s.ecnt - 8'h01;
            n.eaddr = s.eaddr + PAGE_STEP;
            n.st = ST_ERASE;
          end
        end
      end
      ST_FETCH: begin
        if (s.src == SRC_PBUF && !s.loaded[s.addr[5:0]]) begin
          adv = 1'b1;
        end else begin
          n.fl.rd = 1'b1;
          n.fl.addr = s.addr;
          n.xram_rd = (s.src == SRC_XRAM);
          n.xram_addr = s.saddr;
          n.st = ST_RDW;
        end
      end
      ST_RDW: n.st = ST_PROG;
      ST_PROG: begin
        n.fl.wr = 1'b1;
        n.fl.wdata = i_fl_rdata & newdata;
        n.tmr_start = 1'b1;
        n.tmr_count = TMR_W'(PROG_CYC);
        n.st = ST_PWAIT;
      end
      ST_PWAIT: adv = tmr_done;
      default: n.st = ST_IDLE;
    endcase

    if (adv) begin
      if (s.cnt == 8'h01) begin
        n.st = ST_IDLE;
        n.busy = 1'b0;
        n.stall = 1'b0;
        if (s.src == SRC_PBUF) n.loaded = '0;
      end else begin
        n.cnt = s.cnt - 8'h01;
        n.addr = s.addr + 16'h0001;
        n.saddr = s.saddr + 16'h0001;
        n.st = ST_FETCH;
      end
    end

    // Brown-out aborts the cycle; the set wins over a clear
    if (s.bo_s2 && s.busy) begin
      n.err = 1'b1;
      n.busy = 1'b0;
      n.stall = 1'b0;
      n.st = ST_IDLE;
      n.loaded = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end
endmodule

// ===== fspc_fmodel.sv
// Flash array and external RAM model facing the core's memory ports.
// Assumes reads answer one cycle after the strobe; idle lines toggle.
`timescale 1ns/1ns
module fspc_fmodel
  import fspc_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Flash array port
  input wire fspc_fl_cmd_t i_fl,
  output logic [7:0] o_fl_rdata,
  // External RAM port
  input wire logic i_xram_rd,
  input wire logic [15:0] i_xram_addr,
  output logic [7:0] o_xram_rdata
);
  logic [7:0] mem [0:3][0:65535];
  initial begin
    o_fl_rdata = 8'h00;
    o_xram_rdata = 8'h00;
    foreach (mem[s, a]) mem[s][a] = 8'hf5;
  end
  always @(posedge i_ref_clk) begin
    o_fl_rdata <= i_fl.rd ? mem[i_fl.space][i_fl.addr] : ~o_fl_rdata;
    o_xram_rdata <= i_xram_rd ? i_xram_addr[7:0] ^ 8'h3c : ~o_xram_rdata;
    if (i_fl.wr) begin
      // Cells only clear
      mem[i_fl.space][i_fl.addr] <= mem[i_fl.space][i_fl.addr] & i_fl.wdata;
    end
    if (i_fl.erase) begin
      for (int i = 0; i < 128; i++) begin
        mem[i_fl.space][{i_fl.addr[15:7], 7'(i)}] <= 8'hff;
      end
    end
  end
endmodule

// ===== fspc_core_checker.sv
// Port checker of the flash self-programming control core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ns
module fspc_core_checker
  import fspc_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  // CPU and locks
  input wire logic i_exec_internal,
  input wire logic o_cpu_stall,
  input wire logic o_irq_hold,
  input wire logic [2:0][7:0] i_lock_byte,
  input wire logic i_boot_memory_select,
  input wire fspc_lock_t o_lock,
  // Flash array port
  input wire fspc_fl_cmd_t o_fl,
  input wire logic [7:0] i_fl_rdata
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic key5, keya, last_er, seen;
  logic [16:0] gap;
  assign key5 = i_wr && i_addr == REG_FCTL && i_wdata[7:4] == KEY_ARM;
  assign keya = i_wr && i_addr == REG_FCTL && i_wdata[7:4] == KEY_GO
    && i_wdata[2:1] != MODE_NONE;
  // Cycles since the last write or erase pulse
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap <= 17'h00000;
      last_er <= 1'b0;
      seen <= 1'b0;
    end else if (o_fl.wr || o_fl.erase) begin
      gap <= 17'h00000;
      last_er <= o_fl.erase;
      seen <= 1'b1;
    end else if (gap != 17'h1ffff) begin
      gap <= gap + 17'h00001;
    end
  end
  property p_lock0;
    (i_lock_byte == 24'hffffff) [*3] |=> o_lock == 4'h0;
  endproperty
  property p_lock1; (i_lock_byte[0] == 8'h00) [*2] |=> o_lock.prog_block;
  endproperty
  property p_lock2;
    (i_lock_byte[1:0] == 16'h0000) [*2] |=> o_lock.read_block;
  endproperty
  property p_lock3;
    (i_lock_byte == 24'h0 && i_boot_memory_select) [*4]
      |=> o_lock.ext_hi_block;
  endproperty
  property p_lock3n;
    !i_boot_memory_select [*4] |=> !o_lock.ext_hi_block;
  endproperty
  property p_arm;
    keya && $past(key5) && i_exec_internal && !o_cpu_stall |=> o_cpu_stall;
  endproperty
  property p_noarm; keya && !$past(key5) && !o_cpu_stall |=> !o_cpu_stall;
  endproperty
  property p_ext;
    keya && $past(key5) && !i_exec_internal && !o_cpu_stall
      |=> !o_cpu_stall [*4];
  endproperty
  property p_hold; o_cpu_stall && o_fl.wr |=> o_cpu_stall [*8]; endproperty
  property p_irq; o_irq_hold == o_cpu_stall; endproperty
  property p_clear;
    o_fl.wr |-> (o_fl.wdata & ~$past(i_fl_rdata)) == 8'h00;
  endproperty
  property p_gap;
    seen && (o_fl.rd || o_fl.wr || o_fl.erase)
      |-> int'(gap) >= (last_er ? ERASE_CYCLES : PROG_CYC) - 1;
  endproperty
  a_lock0: assert property (p_lock0)
    else $error("protection set with erased locks");
  a_lock1: assert property (p_lock1)
    else $error("programming not blocked");
  a_lock2: assert property (p_lock2)
    else $error("verify read not blocked");
  a_lock3: assert property (p_lock3)
    else $error("external execution not blocked");
  a_lock3n: assert property (p_lock3n)
    else $error("external block without select");
  a_arm: assert property (p_arm)
    else $error("internal launch did not stall");
  a_noarm: assert property (p_noarm)
    else $error("launch without arming key");
  a_ext: assert property (p_ext)
    else $error("external launch stalled the cpu");
  a_hold: assert property (p_hold)
    else $error("stall dropped during programming");
  a_irq: assert property (p_irq)
    else $error("interrupt hold differs from stall");
  a_clear: assert property (p_clear)
    else $error("write sets a bit");
  a_gap: assert property (p_gap)
    else $error("cycle ended before its timer");
  c_stall: cover property ($rose(o_cpu_stall));
  c_erase: cover property (o_fl.erase);
  c_ext: cover property (o_lock.ext_hi_block);
endmodule
bind fspc_core fspc_core_checker #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (
  .i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_exec_internal,
  .o_cpu_stall, .o_irq_hold, .i_lock_byte, .i_boot_memory_select,
  .o_lock, .o_fl, .i_fl_rdata);

// ===== flash_self_programming_control_test.sv
// Self-checking bench of the flash self-programming control core.
// Assumes the flash model and the bound checker are compiled with it.
`timescale 1ns/1ns
module flash_self_programming_control_test;
  import fspc_pkg::*;
  logic i_ref_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, fetch = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, rdata, frd, xrd;
  logic [15:0] pc = 16'h0000, xa;
  logic [2:0][7:0] lock = 24'hffffff;
  logic map = 0, intl = 0, bsel = 0, bo = 0, stall, irqh, xr;
  fspc_lock_t lk;
  fspc_fl_cmd_t fl;
  int n_fail = 0, n_tests = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  fspc_core #(.ERASE_CYCLES(20), .PBUF_DEPTH(64)) i_dut (
    .i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata(rdata), .i_cpu_fetch(fetch), .i_cpu_pc(pc),
    .i_boot_rom_map_enable(map), .i_exec_internal(intl),
    .o_cpu_stall(stall), .o_irq_hold(irqh), .i_lock_byte(lock),
    .i_boot_memory_select(bsel), .o_lock(lk), .o_fl(fl),
    .i_fl_rdata(frd), .o_xram_rd(xr), .o_xram_addr(xa),
    .i_xram_rdata(xrd), .i_brown_out(bo));
  fspc_fmodel i_fm (.i_ref_clk, .i_fl(fl), .o_fl_rdata(frd),
    .i_xram_rd(xr), .i_xram_addr(xa), .o_xram_rdata(xrd));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 0;
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr <= 0;
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 v = rdata;
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      i_wr <= 0;
      i_rd <= 0;
    end
  endtask
  task automatic wait_free;
    logic [7:0] v;
    for (int i = 0; i < 9000; i++) begin
      rd(REG_FCTL, v);
      if (v[FC_BUSY] === 1'b0) return;
    end
    chk("busy", 8'h00, v);
  endtask
  task automatic call(logic [7:0] s, a, logic [15:0] p0, p1);
    wr(REG_SEL, s);
    wr(REG_ACC, a);
    wr(REG_DP0H, p0[15:8]);
    wr(REG_DP0L, p0[7:0]);
    wr(REG_DP1H, p1[15:8]);
    wr(REG_DP1L, p1[7:0]);
    @(posedge i_ref_clk);
    i_wr <= 0;
    map <= 1;
    fetch <= 1;
    pc <= ENTRY_ADDR;
    @(posedge i_ref_clk);
    fetch <= 0;
    map <= 0;
  endtask
  task automatic rt(logic [7:0] s, a, logic [15:0] p0, p1,
    logic [1:0] sp, logic [15:0] ad, logic [7:0] e);
    call(s, a, p0, p1);
    wait_free;
    chk("flash", e, i_fm.mem[sp][ad]);
  endtask
  task automatic bad(logic [7:0] s, a, logic [15:0] p0);
    logic [7:0] v;
    call(s, a, p0, 16'h0000);
    wait_free;
    rd(REG_STAT, v);
    chk("bad_arg", 8'h01, {7'h0, v[ST_BADARG]});
    wr(REG_STAT, 8'h01);
    idle(1);
  endtask
  task automatic t_locks;
    logic [23:0] tb [4];
    tb = '{24'hffffff, 24'hffff00, 24'hff0000, 24'h000000};
    for (int i = 0; i < 4; i++) begin
      @(posedge i_ref_clk);
      lock <= tb[i];
      bsel <= 1;
      fetch <= 1;
      pc <= 16'h9000;
      idle(5);
      chk("lock", {5'h0, i > 2, i > 1, i > 0}, {5'h0, lk.ext_hi_block,
        lk.read_block, lk.prog_block});
      chk("deny", {7'h0, i > 2}, {7'h0, lk.ext_fetch_deny});
    end
    bsel <= 0;
    idle(5);
    chk("ext_hi", 8'h00, {7'h0, lk.ext_hi_block});
    lock <= 24'hffffff;
    fetch <= 0;
    pc <= 16'h0000;
    idle(4);
  endtask
  task automatic t_rout;
    rt(SEL_PBYTE, 8'h3c, 16'h1234, 0, SP_USER, 16'h1234, 8'h34);
    rt(SEL_BOOT, 8'h0f, PTR_BSTAT, 0, SP_USIG, 16'h0000, 8'h05);
    rt(SEL_BOOT, 8'h5a, PTR_BVEC, 0, SP_USIG, 16'h0001, 8'h50);
    rt(SEL_FUSE, FUSE_ON, PTR_CLKX2, 0, SP_FUSE, 16'h0008, 8'h00);
    rt(SEL_FUSE, FUSE_OFF, PTR_BLJ, 0, SP_FUSE, 16'h0004, 8'hf5);
    bad(SEL_FUSE, 8'h02, PTR_BLJ);
  endtask
  task automatic t_erase;
    logic [7:0] b;
    logic [15:0] e;
    for (int i = 0; i < 2; i++) begin
      b = i ? BLK4 : BLK1;
      e = i ? 16'hffff : 16'h3fff;
      rt(SEL_ERASE, 0, {b, 8'h00}, 0, SP_USER, e, 8'hff);
      chk("erase_lo", 8'hff, i_fm.mem[SP_USER][{b, 8'h00}]);
      chk("erase_out", 8'hf5, i_fm.mem[SP_USER][{b, 8'h00} - 1]);
    end
    bad(SEL_ERASE, 0, 16'h1000);
  endtask
  task automatic t_page;
    call(SEL_PPAGE, 8'h03, 16'h0580, 16'h0210);
    wait_free;
    for (int i = 0; i < 4; i++) begin
      chk("page", i < 3 ? ((8'h10 + i) ^ 8'h3c) & 8'hf5 : 8'hf5,
        i_fm.mem[SP_USER][16'h0580 + i]);
    end
    bad(SEL_PPAGE, 8'h00, 16'h0580);
    bad(SEL_PPAGE, 8'h81, 16'h0580);
  endtask
  task automatic t_launch;
    logic [7:0] v;
    wr(REG_FCTL, 8'h08);
    wr(REG_DP0H, 8'h06);
    wr(REG_DP0L, 8'h45);
    wr(REG_PBUF, 8'h0f);
    wr(REG_PBUF, 8'h00);
    idle(1);
    intl <= 1;
    wr(REG_FCTL, 8'h58);
    wr(REG_FCTL, 8'ha8);
    idle(2);
    chk("stall", 8'h01, {7'h0, stall});
    for (int i = 0; i < 3000 && stall === 1'b1; i++) @(posedge i_ref_clk);
    chk("stall_end", 8'h00, {7'h0, stall});
    chk("half", 8'h05, i_fm.mem[SP_USER][16'h0645]);
    rd(REG_FCTL, v);
    chk("busy_end", 8'h00, {7'h0, v[FC_BUSY]});
    wr(REG_FCTL, 8'h58);
    rd(REG_STAT, v);
    wr(REG_FCTL, 8'ha8);
    idle(2);
    rd(REG_FCTL, v);
    chk("abort", 8'h00, {7'h0, v[FC_BUSY] | stall});
    wr(REG_FCTL, 8'h5e);
    wr(REG_FCTL, 8'hae);
    idle(2);
    rd(REG_FCTL, v);
    chk("mode_none", 8'h00, {7'h0, v[FC_BUSY] | stall});
    intl <= 0;
    wr(REG_ECTL, 8'h40);
    wr(REG_DP0H, 8'h07);
    wr(REG_DP0L, 8'h00);
    wr(REG_PBUF, 8'h3c);
    wr(REG_FCTL, 8'h58);
    wr(REG_FCTL, 8'ha8);
    rd(REG_FCTL, v);
    chk("ext_busy", 8'h01, {7'h0, v[FC_BUSY] & ~stall});
    wait_free;
    chk("auto_er", 8'h3c, i_fm.mem[SP_USER][16'h0700]);
    chk("auto_er_pg", 8'hff, i_fm.mem[SP_USER][16'h077f]);
    wr(REG_ECTL, 8'h00);
    wr(REG_FCTL, 8'h00);
    rd(8'h20, v);
    chk("unmapped", 8'h00, v);
  endtask
  task automatic t_brown;
    logic [7:0] v;
    call(SEL_PBYTE, 8'h00, 16'h0100, 16'h0000);
    idle(10);
    bo <= 1;
    idle(4);
    bo <= 0;
    wait_free;
    rd(REG_ECTL, v);
    chk("err", 8'h01, {7'h0, v[EE_ERR]});
    wr(REG_ECTL, 8'h02);
    rd(REG_ECTL, v);
    chk("err_clr", 8'h00, {7'h0, v[EE_ERR]});
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rstn <= 1;
    t_locks;
    t_rout;
    t_erase;
    t_page;
    t_launch;
    t_brown;
    give_verdict;
  end
  initial begin
    #(90000 * 50);
    n_fail++;
    give_verdict;
  end
endmodule
